// file: hdl/sltx_frame_tail.sv
// Link transmit frame tail state machine with its transport word FIFO
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Flop based FIFO, registered full and empty flags
module sltx_fifo #(
    parameter int W = 33,
    parameter int D = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Fill side
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [CW-1:0] cnt;
        logic full;
        logic empty;
    } sltx_fifo_st_t;

    sltx_fifo_st_t s_ff;
    sltx_fifo_st_t nxt_s;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        if (p == AW'(D - 1)) begin
            ptr_inc = '0;
        end else begin
            ptr_inc = AW'(p + 1'b1);
        end
    endfunction : ptr_inc

    assign in_ready = ~s_ff.full;
    assign out_valid = ~s_ff.empty;
    assign out_data = s_ff.mem[s_ff.rptr];
    assign push = in_valid & ~s_ff.full;
    assign pop = out_ready & ~s_ff.empty;

    always_comb begin
        nxt_s = s_ff;
        if (push) begin
            nxt_s.mem[s_ff.wptr] = in_data;
            nxt_s.wptr = ptr_inc(s_ff.wptr);
        end
        if (pop) begin
            nxt_s.rptr = ptr_inc(s_ff.rptr);
        end
        if (push && !pop) begin
            nxt_s.cnt = CW'(s_ff.cnt + 1'b1);
        end else if (pop && !push) begin
            nxt_s.cnt = CW'(s_ff.cnt - 1'b1);
        end
        nxt_s.full = (nxt_s.cnt == CW'(D));
        nxt_s.empty = (nxt_s.cnt == '0);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_ff <= '0;
            s_ff.empty <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

endmodule : sltx_fifo

////////////////////////////////////////////////////////////////////////////
module sltx_frame_tail
    import sltx_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
    parameter logic [31:0] CRC_INIT = CRC_INIT_RST,
    parameter logic [31:0] CRC_POLY = CRC_POLY_DEF,
    parameter bit DMAT_STOP = 1'b1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Transport data words
    input wire sltx_word_t tp_word,
    input wire logic tp_valid,
    output logic tp_ready,
    // Transport control
    input wire logic tp_start,
    input wire logic tp_c0_req,
    input wire logic host_side,
    // Transport results
    output logic res_valid,
    output sltx_res_t res_code,
    output logic dmat_seen,
    output logic busy,
    // Physical layer
    input wire logic phy_rdy_pin,
    input wire sltx_rx_t phy_rx,
    output sltx_tx_t phy_tx
);

    typedef struct packed {
        sltx_state_t st;
        logic [31:0] crc;
        logic dat_done;
        logic flush;
        sltx_tx_t tx;
        logic res_valid;
        sltx_res_t res;
        logic dmat;
        logic busy;
        logic rdy_s1;
        logic rdy_s2;
    } sltx_top_st_t;

    sltx_top_st_t s_ff;
    sltx_top_st_t nxt_s;
    sltx_word_t f_word;
    logic f_valid;
    logic f_pop;
    logic phy_ok;
    logic avail;
    sltx_prim_t rp;

    ////////////////////////////////////////////////////////////////////////
    // Transport word FIFO; its ready back-pressures the transport
    sltx_fifo #(
        .W($bits(sltx_word_t)),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_data(tp_word),
        .in_valid(tp_valid),
        .in_ready(tp_ready),
        .out_data(f_word),
        .out_valid(f_valid),
        .out_ready(f_pop)
    );

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 31; i >= 0; i--) begin
            if (r[31] ^ d[i]) begin
                r = {r[30:0], 1'b0} ^ CRC_POLY;
            end else begin
                r = {r[30:0], 1'b0};
            end
        end
        crc_step = r;
    endfunction : crc_step

    function automatic sltx_tx_t prim_word(input sltx_prim_t p);
        prim_word.prim = p;
        prim_word.dword = DWORD_RST;
    endfunction : prim_word

    assign phy_ok = s_ff.rdy_s2;
    // A dword with a coding error counts as no primitive, except in receive hold, where it acts as HOLD
    assign rp = phy_rx.code_err ? P_OTHER : phy_rx.prim;
    assign avail = f_valid & ~s_ff.flush;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        nxt_s = s_ff;
        f_pop = 1'b0;
        nxt_s.res_valid = 1'b0;
        nxt_s.dmat = 1'b0;
        nxt_s.rdy_s1 = phy_rdy_pin;
        nxt_s.rdy_s2 = s_ff.rdy_s1;
        nxt_s.tx = prim_word(P_SYNC);

        // Leftover words of an ended frame are discarded up to its last one
        if (s_ff.flush && f_valid) begin
            f_pop = 1'b1;
            if (f_word.last) begin
                nxt_s.flush = 1'b0;
            end
        end

        case (s_ff.st)
            ST_IDLE: begin
                if (tp_start && phy_ok && !s_ff.flush) begin
                    nxt_s.st = ST_SOF;
                    nxt_s.crc = CRC_INIT;
                    nxt_s.dat_done = 1'b0;
                    nxt_s.busy = 1'b1;
                end
            end
            ST_SOF: begin
                nxt_s.tx = prim_word(P_SOF);
                nxt_s.st = ST_DATA;
                if (rp == P_SYNC) begin
                    nxt_s.st = ST_IDLE;
                    nxt_s.res_valid = 1'b1;
                    nxt_s.res = RES_ILLEGAL;
                    nxt_s.busy = 1'b0;
                end
            end
            ST_DATA: begin
                if (rp == P_SYNC) begin
                    nxt_s.st = ST_IDLE;
                    nxt_s.res_valid = 1'b1;
                    nxt_s.res = RES_ILLEGAL;
                    nxt_s.busy = 1'b0;
                end else if (rp == P_HOLD) begin
                    nxt_s.tx = prim_word(P_HOLDA);
                    nxt_s.st = ST_RHOLD;
                end else if (rp == P_DMAT && DMAT_STOP) begin
                    nxt_s.tx = prim_word(P_HOLD);
                    nxt_s.dmat = 1'b1;
                    nxt_s.st = ST_CRC;
                end else if (avail) begin
                    f_pop = 1'b1;
                    nxt_s.tx.prim = P_DATA;
                    nxt_s.tx.dword = f_word.dword;
                    nxt_s.crc = crc_step(s_ff.crc, f_word.dword);
                    if (f_word.last) begin
                        nxt_s.dat_done = 1'b1;
                        nxt_s.st = ST_CRC;
                    end
                end else begin
                    nxt_s.tx = prim_word(P_HOLD);
                    nxt_s.st = ST_SHOLD;
                end
            end
            ST_RHOLD: begin
                nxt_s.tx = prim_word(P_HOLDA);
                if (phy_rx.code_err || rp == P_HOLD) begin
                    nxt_s.st = ST_RHOLD;
                end else if (rp == P_SYNC) begin
                    nxt_s.st = ST_IDLE;
                    nxt_s.res_valid = 1'b1;
                    nxt_s.res = RES_ILLEGAL;
                    nxt_s.busy = 1'b0;
                end else if (rp == P_DMAT) begin
                    if (DMAT_STOP) begin
                        nxt_s.dmat = 1'b1;
                        nxt_s.st = ST_CRC;
                    end
                end else if (avail) begin
                    nxt_s.st = ST_DATA;
                end
            end
            ST_SHOLD: begin
                nxt_s.tx = prim_word(P_HOLD);
                if (rp == P_SYNC) begin
                    nxt_s.st = ST_IDLE;
                    nxt_s.res_valid = 1'b1;
                    nxt_s.res = RES_ILLEGAL;
                    nxt_s.busy = 1'b0;
                end else if (rp == P_DMAT) begin
                    if (DMAT_STOP) begin
                        nxt_s.dmat = 1'b1;
                        nxt_s.st = ST_CRC;
                    end
                end else if (avail && rp == P_HOLD) begin
                    nxt_s.st = ST_RHOLD;
                end else if (avail) begin
                    nxt_s.st = ST_DATA;
                end else begin
                    nxt_s.st = ST_SHOLD;
                end
            end
            ST_CRC: begin
                nxt_s.tx.prim = P_CRC;
                nxt_s.tx.dword = s_ff.crc;
                nxt_s.st = ST_EOF;
                // Early DMAT exit leaves words behind; drop them
                if (!s_ff.dat_done) begin
                    nxt_s.flush = 1'b1;
                    nxt_s.dat_done = 1'b1;
                end
                if (rp == P_SYNC) begin
                    nxt_s.st = ST_IDLE;
                    nxt_s.res_valid = 1'b1;
                    nxt_s.res = RES_ILLEGAL;
                    nxt_s.busy = 1'b0;
                end
            end
            ST_EOF: begin
                nxt_s.tx = prim_word(P_EOF);
                nxt_s.st = ST_WAIT;
                if (rp == P_SYNC) begin
                    nxt_s.st = ST_IDLE;
                    nxt_s.res_valid = 1'b1;
                    nxt_s.res = RES_ILLEGAL;
                    nxt_s.busy = 1'b0;
                end
            end
            ST_WAIT: begin
                nxt_s.tx = prim_word(P_WTRM);
                if (rp == P_R_OK) begin
                    nxt_s.st = ST_IDLE;
                    nxt_s.res_valid = 1'b1;
                    nxt_s.res = RES_OK;
                    nxt_s.busy = 1'b0;
                end else if (rp == P_R_ERR) begin
                    nxt_s.st = ST_IDLE;
                    nxt_s.res_valid = 1'b1;
                    nxt_s.res = RES_REMOTE_ERR;
                    nxt_s.busy = 1'b0;
                end else if (rp == P_SYNC) begin
                    nxt_s.st = ST_IDLE;
                    nxt_s.res_valid = 1'b1;
                    nxt_s.res = RES_SYNC_ABORT;
                    nxt_s.busy = 1'b0;
                end
            end
            ST_NOCOMM: begin
                // Stays until the phy comes back, then rests in idle
                if (phy_ok) begin
                    nxt_s.st = ST_IDLE;
                end
            end
            default: begin
                nxt_s.st = ST_IDLE;
                nxt_s.busy = 1'b0;
            end
        endcase

        ////////////////////////////////////////////////////////////////////
        // Exits common to every frame state (no C=0 exit from SOF); later ones win
        if (s_ff.st != ST_IDLE && s_ff.st != ST_NOCOMM) begin
            if (host_side && tp_c0_req && s_ff.st != ST_SOF) begin
                nxt_s.st = ST_IDLE;
                nxt_s.tx = prim_word(P_SYNC);
                nxt_s.res_valid = 1'b1;
                nxt_s.res = RES_HOST_ABORT;
                nxt_s.busy = 1'b0;
                nxt_s.dmat = 1'b0;
                nxt_s.flush = ~nxt_s.dat_done;
                nxt_s.dat_done = 1'b1;
            end
            if (!phy_ok) begin
                nxt_s.st = ST_NOCOMM;
                nxt_s.tx = prim_word(P_SYNC);
                nxt_s.res_valid = 1'b1;
                nxt_s.res = RES_PHY_NRDY;
                nxt_s.busy = 1'b0;
                nxt_s.dmat = 1'b0;
                nxt_s.flush = ~nxt_s.dat_done;
                nxt_s.dat_done = 1'b1;
            end
        end
        // Any other ending by SYNC also leaves words to drop
        if (nxt_s.st == ST_IDLE && s_ff.st != ST_IDLE && !nxt_s.dat_done) begin
            nxt_s.flush = 1'b1;
            nxt_s.dat_done = 1'b1;
        end
        // Idle always sends SYNC, so the far end sees the frame end on the result edge
        if (nxt_s.st == ST_IDLE) begin
            nxt_s.tx = prim_word(P_SYNC);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_ff.st <= ST_IDLE;
            s_ff.crc <= CRC_INIT_RST;
            s_ff.dat_done <= 1'b1;
            s_ff.flush <= 1'b0;
            s_ff.tx.prim <= P_SYNC;
            s_ff.tx.dword <= DWORD_RST;
            s_ff.res_valid <= 1'b0;
            s_ff.res <= RES_OK;
            s_ff.dmat <= 1'b0;
            s_ff.busy <= 1'b0;
            s_ff.rdy_s1 <= 1'b0;
            s_ff.rdy_s2 <= 1'b0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outcome codes and status to the transport, and the transmit word to the physical layer
    assign res_valid = s_ff.res_valid;
    assign res_code = s_ff.res;
    assign dmat_seen = s_ff.dmat;
    assign busy = s_ff.busy;
    assign phy_tx = s_ff.tx;

endmodule : sltx_frame_tail

`default_nettype wire

// file: hdl/sltx_pkg.sv
// Shared types and constants for the link transmit frame tail
package sltx_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths, defaults and reset values
    localparam int DW = 32;
    localparam int FIFO_DEPTH_DEF = 8;
    localparam logic [31:0] CRC_INIT_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] CRC_POLY_DEF = 32'h04C1_1DB7;
    localparam logic [31:0] DWORD_RST = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Decoded primitive codes, both directions
    typedef enum logic [3:0] {
        P_OTHER = 4'h0,
        P_DATA  = 4'h1,
        P_HOLD  = 4'h2,
        P_HOLDA = 4'h3,
        P_SYNC  = 4'h4,
        P_DMAT  = 4'h5,
        P_R_OK  = 4'h6,
        P_R_ERR = 4'h7,
        P_WTRM  = 4'h8,
        P_SOF   = 4'h9,
        P_EOF   = 4'hA,
        P_CRC   = 4'hB
    } sltx_prim_t;

    // Frame outcome codes towards the transport layer
    typedef enum logic [2:0] {
        RES_OK         = 3'h0,
        RES_REMOTE_ERR = 3'h1,
        RES_ILLEGAL    = 3'h2,
        RES_SYNC_ABORT = 3'h3,
        RES_PHY_NRDY   = 3'h4,
        RES_HOST_ABORT = 3'h5
    } sltx_res_t;

    // Gray codes along idle, sof, data, crc, eof, wait
    typedef enum logic [3:0] {
        ST_IDLE   = 4'h0,
        ST_SOF    = 4'h1,
        ST_DATA   = 4'h3,
        ST_CRC    = 4'h2,
        ST_EOF    = 4'h6,
        ST_WAIT   = 4'h7,
        ST_RHOLD  = 4'h5,
        ST_SHOLD  = 4'h4,
        ST_NOCOMM = 4'hC
    } sltx_state_t;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic last;
        logic [DW-1:0] dword;
    } sltx_word_t;

    typedef struct packed {
        sltx_prim_t prim;
        logic code_err;
        logic [DW-1:0] dword;
    } sltx_rx_t;

    typedef struct packed {
        sltx_prim_t prim;
        logic [DW-1:0] dword;
    } sltx_tx_t;

endpackage : sltx_pkg

// file: testbench/sltx_far_end.sv
// Far-end link layer model feeding the received dword stream
`timescale 1ns/1ps
`default_nettype none

module sltx_far_end
    import sltx_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Commands from the bench
    input wire sltx_prim_t cmd,
    input wire logic err,
    input wire sltx_prim_t ans,
    input wire logic [3:0] ans_dly,
    // Link
    input wire sltx_tx_t phy_tx,
    output var sltx_rx_t phy_rx
);
    logic [3:0] wait_cnt;
    logic [31:0] noise;

    ////////////////////////////////////////////////////////////////////////
    // Dword payload of primitives is meaningless, so it changes every cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wait_cnt <= 4'h0;
            noise <= 32'h0000_0000;
            phy_rx <= {P_SYNC, 1'b0, 32'h0000_0000};
        end else begin
            noise <= {noise[30:0], ~noise[31]};
            if (phy_tx.prim == P_WTRM && wait_cnt != 4'hF) begin
                wait_cnt <= wait_cnt + 4'h1;
            end else begin
                wait_cnt <= 4'h0;
            end
            // Status answer after ans_dly cycles of WTRM, prompt when zero
            phy_rx.prim <= (phy_tx.prim == P_WTRM && wait_cnt >= ans_dly) ? ans : cmd;
            phy_rx.code_err <= err;
            phy_rx.dword <= noise;
        end
    end

endmodule : sltx_far_end

`default_nettype wire

// file: testbench/sltx_frame_tail_props.sv
// Concurrent checks on the ports of the link transmit frame tail
`timescale 1ns/1ps
`default_nettype none

module sltx_frame_tail_props
    import sltx_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Transport
    input wire logic tp_c0_req,
    input wire logic host_side,
    input wire logic res_valid,
    input wire sltx_res_t res_code,
    input wire logic busy,
    // Physical layer
    input wire logic phy_rdy_pin,
    input wire sltx_rx_t phy_rx,
    input wire sltx_tx_t phy_tx
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic [2:0] rdy_ff;
    logic rdy_ok, c0, quiet, sync_in, nr, stay;

    // Pin history; the design sees the pin only through a two-stage synchroniser
    always_ff @(posedge sys_clk) begin
        rdy_ff <= {rdy_ff[1:0], phy_rdy_pin};
    end

    assign rdy_ok = (&rdy_ff) && phy_rdy_pin;
    assign c0 = host_side && tp_c0_req;
    assign sync_in = phy_rx.prim == P_SYNC && !phy_rx.code_err && rdy_ok && !c0;
    assign quiet = rdy_ok && !c0 && !(phy_rx.prim == P_SYNC && !phy_rx.code_err);
    assign stay = !c0 && !(phy_rx.prim inside {P_R_OK, P_R_ERR, P_SYNC});
    assign nr = !phy_rdy_pin && stay;

    ////////////////////////////////////////////////////////////////////////
    sequence illegal_s;
        res_valid && res_code == RES_ILLEGAL && phy_tx.prim == P_SYNC && !busy;
    endsequence

    sequence tail_s;
        phy_tx.prim == P_EOF ##1 phy_tx.prim == P_WTRM;
    endsequence

    rhold_stay_a: assert property (
        phy_tx.prim == P_HOLDA && rdy_ok && !c0 && (phy_rx.prim == P_HOLD || phy_rx.code_err)
        |=> phy_tx.prim == P_HOLDA) else $error("receiver hold left early");
    rhold_sync_a: assert property (
        phy_tx.prim == P_HOLDA && sync_in |=> illegal_s) else $error("sync in hold missed");
    shold_sync_a: assert property (
        phy_tx.prim inside {P_HOLD, P_CRC} && sync_in |=> illegal_s)
        else $error("sync in send states missed");
    tail_order_a: assert property (
        phy_tx.prim == P_CRC && quiet ##1 quiet && !(phy_rx.prim inside {P_R_OK, P_R_ERR})
        |-> tail_s) else $error("bad frame tail");
    wait_stay_a: assert property (
        phy_tx.prim == P_WTRM && quiet
        && !(phy_rx.prim inside {P_R_OK, P_R_ERR} && !phy_rx.code_err)
        |=> phy_tx.prim == P_WTRM && !res_valid) else $error("wait left early");
    wait_ok_a: assert property (
        phy_tx.prim == P_WTRM && quiet && phy_rx.prim == P_R_OK && !phy_rx.code_err
        |=> res_valid && res_code == RES_OK && !busy) else $error("good status not reported");
    wait_fail_a: assert property (
        phy_tx.prim == P_WTRM && rdy_ok && !c0 && !phy_rx.code_err
        && phy_rx.prim inside {P_R_ERR, P_SYNC} |=> res_valid
        && res_code == (($past(phy_rx.prim) == P_SYNC) ? RES_SYNC_ABORT : RES_REMOTE_ERR))
        else $error("failed status not reported");
    dmat_crc_a: assert property (
        phy_tx.prim inside {P_HOLD, P_HOLDA} && quiet && phy_rx.prim == P_DMAT
        && !phy_rx.code_err ##1 quiet |-> ##[0:1] phy_tx.prim == P_CRC)
        else $error("dmat did not end data");
    c0_abort_a: assert property (
        c0 && rdy_ok && phy_tx.prim inside {P_DATA, P_HOLD, P_HOLDA, P_CRC, P_EOF, P_WTRM}
        |=> res_valid && res_code == RES_HOST_ABORT && phy_tx.prim == P_SYNC)
        else $error("host abort missed");
    phy_nrdy_a: assert property (
        phy_tx.prim inside {P_HOLD, P_HOLDA, P_WTRM} && rdy_ok && stay ##1 nr ##1 nr
        |-> ##[1:3] (res_valid && res_code == RES_PHY_NRDY)) else $error("phy loss missed");

endmodule : sltx_frame_tail_props

bind sltx_frame_tail sltx_frame_tail_props props_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .tp_c0_req(tp_c0_req), .host_side(host_side),
    .res_valid(res_valid), .res_code(res_code), .busy(busy), .phy_rdy_pin(phy_rdy_pin),
    .phy_rx(phy_rx), .phy_tx(phy_tx));

`default_nettype wire

// file: testbench/sltx_frame_tail_tb.sv
// Self-checking bench for the link transmit frame tail
`timescale 1ns/1ps
`default_nettype none

module sltx_frame_tail_tb;
    import sltx_pkg::*;

    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    sltx_word_t tp_word = '0;
    logic tp_valid = 1'b0;
    logic tp_start = 1'b0;
    logic tp_c0_req = 1'b0;
    logic host_side = 1'b0;
    logic phy_rdy_pin = 1'b1;
    sltx_prim_t cmd = P_OTHER;
    sltx_prim_t ans = P_OTHER;
    logic err = 1'b0;
    logic [3:0] ans_dly = 4'h0;
    logic tp_ready, res_valid, dmat_seen, busy;
    sltx_res_t res_code;
    sltx_rx_t phy_rx;
    sltx_tx_t phy_tx;
    int errors = 0;
    int num_checks = 0;

    sltx_frame_tail dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .tp_word(tp_word),
        .tp_valid(tp_valid), .tp_ready(tp_ready), .tp_start(tp_start), .tp_c0_req(tp_c0_req),
        .host_side(host_side), .res_valid(res_valid), .res_code(res_code),
        .dmat_seen(dmat_seen), .busy(busy), .phy_rdy_pin(phy_rdy_pin), .phy_rx(phy_rx),
        .phy_tx(phy_tx));

    sltx_far_end far_u (.sys_clk(sys_clk), .rst_n(rst_n), .cmd(cmd), .err(err), .ans(ans),
        .ans_dly(ans_dly), .phy_tx(phy_tx), .phy_rx(phy_rx));

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(string what, logic [35:0] seen, logic [35:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        if (errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    task automatic tick(int n = 1);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic put(logic last, logic [31:0] d);
        @(posedge sys_clk);
        tp_word <= {last, d};
        tp_valid <= 1'b1;
        do @(posedge sys_clk); while (tp_ready !== 1'b1);
        tp_valid <= 1'b0;
    endtask : put

    // Start is held until taken, since idle may still be flushing an aborted frame
    task automatic start();
        @(posedge sys_clk);
        tp_start <= 1'b1;
        do @(posedge sys_clk); while (busy !== 1'b1);
        tp_start <= 1'b0;
        #1;
    endtask : start

    task automatic far(sltx_prim_t c, logic e = 1'b0);
        @(posedge sys_clk);
        cmd <= c;
        err <= e;
    endtask : far

    task automatic answer(sltx_prim_t a, logic [3:0] d);
        @(posedge sys_clk);
        ans <= a;
        ans_dly <= d;
    endtask : answer

    task automatic wait_tx(sltx_prim_t p, string what);
        for (int n = 0; n < 40 && phy_tx.prim !== p; n++) tick();
        check(what, phy_tx.prim, p);
    endtask : wait_tx

    task automatic wait_res(sltx_res_t c);
        for (int n = 0; n < 60 && res_valid !== 1'b1; n++) tick();
        check("result", res_code, c);
        check("busy", busy, 1'b0);
    endtask : wait_res

    function automatic logic [31:0] crc_step(logic [31:0] c, logic [31:0] d);
        for (int i = 31; i >= 0; i--) begin
            c = (c[31] ^ d[i]) ? {c[30:0], 1'b0} ^ CRC_POLY_DEF : {c[30:0], 1'b0};
        end
        return c;
    endfunction : crc_step

    ////////////////////////////////////////////////////////////////////////
    task automatic t_good();
        logic [31:0] crc;
        crc = crc_step(crc_step(CRC_INIT_RST, 32'h1234_5678), 32'hA5A5_0F0F);
        put(1'b0, 32'h1234_5678);
        put(1'b1, 32'hA5A5_0F0F);
        answer(P_R_OK, 4'h0);
        start();
        wait_tx(P_SOF, "sof");
        tick();
        check("word0", phy_tx, {P_DATA, 32'h1234_5678});
        tick();
        check("word1", phy_tx, {P_DATA, 32'hA5A5_0F0F});
        tick();
        check("crc", phy_tx, {P_CRC, crc});
        tick();
        check("eof", phy_tx, {P_EOF, DWORD_RST});
        tick();
        check("wtrm", phy_tx.prim, P_WTRM);
        wait_res(RES_OK);
        check("idle", phy_tx, {P_SYNC, DWORD_RST});
    endtask : t_good

    // Send-hold on a dry FIFO, then each status answer, after 0, 3 and 6 cycles of WTRM
    task automatic t_answers();
        sltx_prim_t a [3] = '{P_R_OK, P_R_ERR, P_SYNC};
        sltx_res_t r [3] = '{RES_OK, RES_REMOTE_ERR, RES_SYNC_ABORT};
        for (int i = 0; i < 3; i++) begin
            answer(a[i], 4'(3 * i));
            put(1'b0, 32'(i));
            start();
            wait_tx(P_HOLD, "dry");
            tick(3);
            check("dry hold", phy_tx.prim, P_HOLD);
            put(1'b1, 32'h0000_00F0);
            wait_tx(P_DATA, "resume");
            wait_tx(P_WTRM, "wtrm");
            wait_res(r[i]);
        end
    endtask : t_answers

    // Fill until refused, stall with HOLD, end early by DMAT, flush the rest
    task automatic t_fill();
        for (int i = 0; i < FIFO_DEPTH_DEF; i++) put(i == FIFO_DEPTH_DEF - 1, 32'(i));
        tick();
        check("full", tp_ready, 1'b0);
        far(P_HOLD);
        answer(P_R_OK, 4'h1);
        start();
        wait_tx(P_HOLDA, "holda");
        tick(4);
        check("stall", phy_tx.prim, P_HOLDA);
        far(P_OTHER, 1'b1);
        tick(3);
        check("code err", phy_tx.prim, P_HOLDA);
        far(P_DMAT);
        for (int n = 0; n < 10 && dmat_seen !== 1'b1; n++) tick();
        check("dmat seen", dmat_seen, 1'b1);
        wait_tx(P_CRC, "dmat");
        far(P_OTHER);
        wait_res(RES_OK);
        for (int n = 0; n < 20 && tp_ready !== 1'b1; n++) tick();
        check("drained", tp_ready, 1'b1);
    endtask : t_fill

    task automatic t_sync_rhold();
        put(1'b1, 32'h0000_00AA);
        far(P_HOLD);
        start();
        wait_tx(P_HOLDA, "rhold");
        far(P_SYNC);
        wait_res(RES_ILLEGAL);
        far(P_OTHER);
    endtask : t_sync_rhold

    // Send-hold exits: SYNC, phy loss, and C=0 arriving with SYNC in one cycle
    task automatic t_shold_abort();
        sltx_res_t r [3] = '{RES_ILLEGAL, RES_PHY_NRDY, RES_HOST_ABORT};
        @(posedge sys_clk);
        host_side <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            put(1'b0, 32'h0000_0055);
            start();
            wait_tx(P_HOLD, "shold");
            @(posedge sys_clk);
            cmd <= (i != 1) ? P_SYNC : P_OTHER;
            phy_rdy_pin <= (i != 1);
            @(posedge sys_clk);
            tp_c0_req <= (i == 2);
            wait_res(r[i]);
            check("sync out", phy_tx.prim, P_SYNC);
            @(posedge sys_clk);
            cmd <= P_OTHER;
            phy_rdy_pin <= 1'b1;
            tp_c0_req <= 1'b0;
            put(1'b1, 32'h0000_0066);
        end
    endtask : t_shold_abort

    task automatic t_c0_wait();
        answer(P_OTHER, 4'h0);
        put(1'b1, 32'h0000_0077);
        start();
        wait_tx(P_WTRM, "wait");
        tick(3);
        check("waiting", phy_tx.prim, P_WTRM);
        @(posedge sys_clk);
        tp_c0_req <= 1'b1;
        wait_res(RES_HOST_ABORT);
        @(posedge sys_clk);
        tp_c0_req <= 1'b0;
    endtask : t_c0_wait

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        tick(3);
        check("rst tx", phy_tx, {P_SYNC, DWORD_RST});
        check("rst ready", tp_ready, 1'b1);
        t_good();
        t_answers();
        t_fill();
        t_sync_rhold();
        t_shold_abort();
        t_c0_wait();
        end_sim();
    end

    // The whole run needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge sys_clk);
        errors++;
        end_sim();
    end

endmodule : sltx_frame_tail_tb

`default_nettype wire
